// ===== core/tfsl_pkg.sv
// Package with register map, field positions and constants for the transmitter fault status logic.
package tfsl_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TFSL_ADDR_STATUS = 8'h00;
  localparam logic [7:0] TFSL_ADDR_EVENT  = 8'h04;
  localparam logic [7:0] TFSL_ADDR_MASK   = 8'h08;
  localparam logic [7:0] TFSL_ADDR_CTRL   = 8'h0c;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int TFSL_NUM_SUPPLY = 5;
  localparam int TFSL_BIT_CONV   = 5;
  localparam int TFSL_BIT_FUSE   = 6;
  localparam int TFSL_BIT_OSC    = 7;
  localparam int TFSL_BIT_BUF    = 8;
  localparam int TFSL_BIT_PRE    = 9;
  localparam int TFSL_NUM_FLT    = 10;
  localparam int TFSL_BIT_SHUT   = 10;
  localparam int TFSL_BIT_OSCEN  = 11;
  localparam int TFSL_CTRL_TEST  = 0;
  localparam logic [TFSL_NUM_FLT-1:0] TFSL_MASK_RST = 10'h000;
  localparam logic [1:0] TFSL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TFSL_RESP_SLVERR = 2'h2;
endpackage : tfsl_pkg

// ===== core/tfsl_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module tfsl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  // Flops reset to zero; the XOR with rst_val on input and output makes sync_out reset to rst_val.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in ^ rst_val;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q ^ rst_val;
endmodule : tfsl_sync
`default_nettype wire

// ===== core/tfsl_top.sv
// Transmitter fault status logic: indications, shutdown, oscillator enable and AXI4-Lite registers.
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tfsl_top (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  // Fault and control pins
  input  wire logic [tfsl_pkg::TFSL_NUM_SUPPLY-1:0] supply_flag_n,
  input  wire logic                              conv_error,
  input  wire logic                              indication_block_n,
  input  wire logic                              fuse_blown,
  input  wire logic                              osc_loss,
  input  wire logic                              buf_loss,
  input  wire logic                              pre_loss,
  input  wire logic                              tx_on,
  input  wire logic                              pa_supply_on,
  input  wire logic                              turn_on_request,
  input  wire logic                              osc_test_button,
  // Indications and commands
  output logic [tfsl_pkg::TFSL_NUM_SUPPLY-1:0]   supply_green,
  output logic [tfsl_pkg::TFSL_NUM_SUPPLY-1:0]   supply_red,
  output logic [tfsl_pkg::TFSL_NUM_SUPPLY-1:0]   supply_ext,
  output logic                                   conv_green,
  output logic                                   conv_red,
  output logic                                   conv_ext,
  output logic                                   audio_latch_clear,
  output logic                                   fuse_lamp,
  output logic                                   fuse_green,
  output logic [2:0]                             rf_green,
  output logic [2:0]                             rf_red,
  output logic [2:0]                             rf_ext,
  output logic                                   amplifier_shutdown,
  output logic                                   pa_supply_hold,
  output logic                                   osc_enable,
  output logic                                   irq,
  // AXI4-Lite slave
  input  wire logic [7:0]                        s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [7:0]                        s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);
  localparam int NS  = tfsl_pkg::TFSL_NUM_SUPPLY;
  localparam int NF  = tfsl_pkg::TFSL_NUM_FLT;
  localparam int NIN = NS + 10;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] rst_pol;
  logic [NIN-1:0] syn_in;
  assign raw_in  = {osc_test_button, turn_on_request, pa_supply_on, tx_on, pre_loss, buf_loss,
                    osc_loss, fuse_blown, indication_block_n, conv_error, supply_flag_n};
  // Active-low lines settle to their released level during reset.
  assign rst_pol = {10'h002, {NS{1'b1}}};
  tfsl_sync #(
    .WIDTH (NIN)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in (raw_in),
    .rst_val  (rst_pol),
    .sync_out (syn_in)
  );

  wire [NS-1:0] s_flag_n  = syn_in[NS-1:0];
  wire          s_conv    = syn_in[NS];
  wire          s_block_n = syn_in[NS+1];
  wire          s_fuse    = syn_in[NS+2];
  wire          s_osc     = syn_in[NS+3];
  wire          s_buf     = syn_in[NS+4];
  wire          s_pre     = syn_in[NS+5];
  wire          s_tx_on   = syn_in[NS+6];
  wire          s_pa_on   = syn_in[NS+7];
  wire          s_req     = syn_in[NS+8];
  wire          s_button  = syn_in[NS+9];

  // ----------------------------------------------------------------
  // Fault decoding
  // ----------------------------------------------------------------
  logic test_force_q;
  // A released flag line floats high, so a low level is the fault.
  wire [NS-1:0] supply_fault = ~s_flag_n;
  wire          conv_shown   = s_conv & s_block_n;
  wire          osc_shown    = s_osc & s_tx_on;
  wire          buf_shown    = s_buf & ~osc_shown;
  wire          pre_shown    = s_pre & ~osc_shown & ~buf_shown;
  wire [2:0]    rf_shown     = {pre_shown, buf_shown, osc_shown};
  // Supply faults and, of the RF stages, only the predriver feed shutdown; the other RF stages are indications.
  wire          shut_d       = (|supply_fault) | pre_shown;
  wire          osc_en_d     = s_req | (~s_pa_on & (s_button | test_force_q));
  wire [NF-1:0] fault_vec    = {rf_shown, s_fuse, conv_shown, supply_fault};

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      supply_red         <= '0;
      supply_green       <= '0;
      supply_ext         <= '0;
      conv_red           <= 1'b0;
      conv_green         <= 1'b0;
      conv_ext           <= 1'b0;
      audio_latch_clear  <= 1'b0;
      fuse_lamp          <= 1'b0;
      fuse_green         <= 1'b0;
      rf_red             <= '0;
      rf_green           <= '0;
      rf_ext             <= '0;
      amplifier_shutdown <= 1'b0;
      osc_enable         <= 1'b0;
    end else begin
      supply_red         <= supply_fault;
      supply_green       <= ~supply_fault;
      supply_ext         <= supply_fault;
      conv_red           <= conv_shown;
      conv_green         <= ~conv_shown;
      conv_ext           <= conv_shown;
      audio_latch_clear  <= s_conv;
      fuse_lamp          <= s_fuse;
      fuse_green         <= ~s_fuse;
      rf_red             <= rf_shown;
      rf_green           <= ~rf_shown;
      rf_ext             <= rf_shown;
      amplifier_shutdown <= shut_d;
      osc_enable         <= osc_en_d;
    end
  end
  // Shutdown never drops the amplifier supply.
  assign pa_supply_hold = 1'b1;

  // ----------------------------------------------------------------
  // Sticky events, mask and interrupt
  // ----------------------------------------------------------------
  logic [NF-1:0] fault_prev_q;
  logic [NF-1:0] event_q;
  logic [NF-1:0] event_d;
  logic [NF-1:0] mask_q;
  logic [NF-1:0] ev_clr;
  wire  [NF-1:0] ev_set = fault_vec & ~fault_prev_q;
  // Set wins over a simultaneous write-one-to-clear.
  assign event_d = ev_set | (event_q & ~ev_clr);
  assign irq     = |(event_q & mask_q);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       aw_full_q;
  logic       w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;
  logic       rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready  = ~w_full_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire aw_have = aw_full_q | (s_axi_awvalid & s_axi_awready);
  wire w_have  = w_full_q | (s_axi_wvalid & s_axi_wready);
  wire wr_go   = aw_have & w_have & ~bvalid_q;
  wire [7:0]  wr_addr = aw_full_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_full_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_full_q ? w_strb_q : s_axi_wstrb;
  wire [31:0] wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wr_bits = wr_data & wr_mask;
  wire wr_event = wr_go & (wr_addr == tfsl_pkg::TFSL_ADDR_EVENT);
  wire wr_mask_hit = wr_go & (wr_addr == tfsl_pkg::TFSL_ADDR_MASK);
  wire wr_ctrl = wr_go & (wr_addr == tfsl_pkg::TFSL_ADDR_CTRL);
  wire wr_ok   = wr_event | wr_mask_hit | wr_ctrl |
                 (wr_go & (wr_addr == tfsl_pkg::TFSL_ADDR_STATUS));
  assign ev_clr = wr_event ? wr_bits[NF-1:0] : '0;
  wire [NF-1:0] mask_d = wr_mask_hit ? ((mask_q & ~wr_mask[NF-1:0]) | wr_bits[NF-1:0]) : mask_q;
  wire test_force_d = (wr_ctrl & wr_strb[0]) ? wr_data[tfsl_pkg::TFSL_CTRL_TEST] : test_force_q;

  wire [31:0] status_word = {20'h00000, osc_enable, amplifier_shutdown,
                             rf_red, fuse_lamp, conv_red, supply_red};
  wire        rd_go  = s_axi_arvalid & s_axi_arready;
  wire        rd_st  = s_axi_araddr == tfsl_pkg::TFSL_ADDR_STATUS;
  wire        rd_ev  = s_axi_araddr == tfsl_pkg::TFSL_ADDR_EVENT;
  wire        rd_mk  = s_axi_araddr == tfsl_pkg::TFSL_ADDR_MASK;
  wire        rd_ct  = s_axi_araddr == tfsl_pkg::TFSL_ADDR_CTRL;
  wire [31:0] rd_word = rd_st ? status_word :
                        rd_ev ? {22'h000000, event_q} :
                        rd_mk ? {22'h000000, mask_q} :
                        rd_ct ? {31'h00000000, test_force_q} : 32'h00000000;
  wire        rd_ok  = rd_st | rd_ev | rd_mk | rd_ct;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fault_prev_q <= '0;
      event_q      <= '0;
      mask_q       <= tfsl_pkg::TFSL_MASK_RST;
      test_force_q <= 1'b0;
    end else begin
      fault_prev_q <= fault_vec;
      event_q      <= event_d;
      mask_q       <= mask_d;
      test_force_q <= test_force_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= tfsl_pkg::TFSL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? tfsl_pkg::TFSL_RESP_OKAY : tfsl_pkg::TFSL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= tfsl_pkg::TFSL_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_ok ? tfsl_pkg::TFSL_RESP_OKAY : tfsl_pkg::TFSL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule : tfsl_top
`default_nettype wire

// ===== testbench/tfsl_far_model.sv
// Far-side model: regulator flag lines and the controller's indication block.
`timescale 1ns/10ps
`default_nettype none
module tfsl_far_model (
  input  wire logic [4:0] reg_fault,
  input  wire logic       tx_on,
  input  wire logic       amp_held,
  input  wire logic       amplifier_shutdown,
  output logic      [4:0] supply_flag_n,
  output logic            indication_block_n
);
  // A healthy regulator leaves its line open, so the pull-up reads high.
  assign supply_flag_n = ~reg_fault;
  // The block is held while off, during step-start and after a fault shutdown.
  assign indication_block_n = tx_on && !amp_held && !amplifier_shutdown;
endmodule : tfsl_far_model
`default_nettype wire

// ===== testbench/tfsl_asserts.sv
// Concurrent checks on the pins of the transmitter fault status logic.
`timescale 1ns/10ps
`default_nettype none
module tfsl_checker (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [4:0] supply_flag_n,
  input wire logic       conv_error,
  input wire logic       indication_block_n,
  input wire logic       fuse_blown,
  input wire logic       osc_loss,
  input wire logic       buf_loss,
  input wire logic       pre_loss,
  input wire logic       tx_on,
  input wire logic       pa_supply_on,
  input wire logic       turn_on_request,
  input wire logic       osc_test_button,
  input wire logic [4:0] supply_red,
  input wire logic       conv_red,
  input wire logic       audio_latch_clear,
  input wire logic       fuse_lamp,
  input wire logic [2:0] rf_red,
  input wire logic       amplifier_shutdown,
  input wire logic       pa_supply_hold,
  input wire logic       osc_enable,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready
);
  // ------------------------------------------------------------
  // Settling
  // ------------------------------------------------------------
  // Pins reach outputs three edges late, so checks wait until that history is all post-reset.
  logic [1:0] up_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  function automatic logic [2:0] rf_exp(logic o, logic b, logic p, logic t);
    return {p && !b && !(o && t), b && !(o && t), o && t};
  endfunction : rf_exp
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_settled;
    up_q == 2'h3;
  endsequence
  sequence s_resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_SUPPLY_RED: assert property (s_settled |-> supply_red == ~$past(supply_flag_n, 3))
    else $error("supply red does not follow the flags");
  AST_SHUTDOWN: assert property (s_settled |-> amplifier_shutdown == ((~&$past(supply_flag_n, 3)) ||
    $past(pre_loss && !buf_loss && !(osc_loss && tx_on), 3)))
    else $error("amplifier shutdown wrong");
  AST_HOLD: assert property (pa_supply_hold)
    else $error("amplifier supply released");
  AST_CONV: assert property (s_settled |-> conv_red == $past(conv_error && indication_block_n, 3))
    else $error("conversion indication wrong");
  AST_LATCH: assert property (s_settled |-> audio_latch_clear == $past(conv_error, 3))
    else $error("audio latch clear wrong");
  AST_FUSE: assert property (s_settled |-> fuse_lamp == $past(fuse_blown, 3))
    else $error("fuse lamp wrong");
  AST_RF: assert property (s_settled |->
    rf_red == rf_exp($past(osc_loss, 3), $past(buf_loss, 3), $past(pre_loss, 3), $past(tx_on, 3)))
    else $error("rf indication wrong");
  AST_OSC_ON: assert property (s_settled ##0
    $past(turn_on_request || (!pa_supply_on && osc_test_button), 3) |-> osc_enable)
    else $error("oscillator not enabled");
  AST_OSC_OFF: assert property (s_settled ##0 $past(pa_supply_on && !turn_on_request, 3) |-> !osc_enable)
    else $error("oscillator enabled with supply on and no request");
  AST_BRESP_HOLD: assert property (s_resp_wait |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule : tfsl_checker
bind tfsl_top tfsl_checker tfsl_checker_inst (.clock, .rst_b, .supply_flag_n, .conv_error, .indication_block_n,
  .fuse_blown, .osc_loss, .buf_loss, .pre_loss, .tx_on, .pa_supply_on, .turn_on_request, .osc_test_button,
  .supply_red, .conv_red, .audio_latch_clear, .fuse_lamp, .rf_red, .amplifier_shutdown, .pa_supply_hold,
  .osc_enable, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire

// ===== testbench/tfsl_top_tb.sv
// Self-checking testbench for the transmitter fault status logic.
`timescale 1ns/10ps
`default_nettype none
module tfsl_top_tb;
  logic clock, rst_b, conv_error, fuse_blown, osc_loss, buf_loss, pre_loss, tx_on, pa_supply_on, amp_held;
  logic turn_on_request, osc_test_button, indication_block_n, conv_green, conv_red, conv_ext, audio_latch_clear;
  logic fuse_lamp, fuse_green, amplifier_shutdown, pa_supply_hold, osc_enable, irq;
  logic [4:0] reg_fault, supply_flag_n, supply_green, supply_red, supply_ext, m;
  logic [2:0] rf_green, rf_red, rf_ext, e;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count, checks, cyc, i;
  tfsl_top tfsl_top_inst (.clock, .rst_b, .supply_flag_n, .conv_error, .indication_block_n, .fuse_blown,
    .osc_loss, .buf_loss, .pre_loss, .tx_on, .pa_supply_on, .turn_on_request, .osc_test_button, .supply_green,
    .supply_red, .supply_ext, .conv_green, .conv_red, .conv_ext, .audio_latch_clear, .fuse_lamp, .fuse_green,
    .rf_green, .rf_red, .rf_ext, .amplifier_shutdown, .pa_supply_hold, .osc_enable, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tfsl_far_model tfsl_far_model_inst (.reg_fault, .tx_on, .amp_held, .amplifier_shutdown, .supply_flag_n,
    .indication_block_n);
  // ------------------------------------------------------------
  // Common tasks
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // Pins need three edges to reach outputs; reading after a falling edge avoids update races.
  task settle;
    repeat (5) @(posedge clock);
    @(negedge clock);
  endtask : settle
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(negedge clock);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    chk("bresp", r, er);
  endtask : axw
  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(negedge clock);
      ar_t = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
        @(posedge clock);
        s_axi_rready <= 1'b0;
        break;
      end
      @(posedge clock);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
  endtask : axr
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_supply;
    for (i = 0; i < 5; i++) begin
      @(posedge clock);
      m = 5'h01 << i;
      reg_fault <= m;
      settle();
      chk("supply_red", supply_red, m);
      chk("supply_ext", supply_ext, m);
      chk("supply_green", supply_green ^ m, 5'h1f);
      chk("shutdown", amplifier_shutdown, 1'b1);
      chk("supply_hold", pa_supply_hold, 1'b1);
    end
    @(posedge clock);
    reg_fault <= 5'h00;
    settle();
    chk("supply_green", supply_green, 5'h1f);
  endtask : t_supply
  task t_conv;
    @(posedge clock);
    conv_error <= 1'b1;
    settle();
    chk("conv_red", {conv_red, conv_ext, conv_green}, 3'h6);
    chk("latch_clear", audio_latch_clear, 1'b1);
    @(posedge clock);
    amp_held <= 1'b1;
    settle();
    chk("conv_held", {conv_red, conv_ext, conv_green}, 3'h1);
    chk("latch_clear", audio_latch_clear, 1'b1);
    @(posedge clock);
    amp_held <= 1'b0;
    conv_error <= 1'b0;
    fuse_blown <= 1'b1;
    settle();
    chk("fuse", {fuse_lamp, fuse_green, amplifier_shutdown}, 3'h4);
    @(posedge clock);
    fuse_blown <= 1'b0;
  endtask : t_conv
  task t_rf;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      {tx_on, pre_loss, buf_loss, osc_loss} <= i[3:0];
      settle();
      e[0] = i[0] && i[3];
      e[1] = i[1] && !e[0];
      e[2] = i[2] && !i[1] && !e[0];
      chk("rf_red", rf_red, e);
      chk("rf_green", rf_green ^ e, 3'h7);
      chk("rf_ext", rf_ext, e);
      chk("rf_shutdown", amplifier_shutdown, e[2]);
    end
  endtask : t_rf
  task t_osc;
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      {pa_supply_on, turn_on_request, osc_test_button} <= i[2:0];
      settle();
      chk("osc_enable", osc_enable, i[1] || (!i[2] && i[0]));
    end
  endtask : t_osc
  task t_regs;
    // Quiet the RF and oscillator pins so the status word holds only the fuse fault.
    @(posedge clock);
    {osc_loss, buf_loss, pre_loss, turn_on_request, osc_test_button} <= 5'h00;
    settle();
    axr(tfsl_pkg::TFSL_ADDR_MASK, 32'h0, tfsl_pkg::TFSL_RESP_OKAY);
    axw(tfsl_pkg::TFSL_ADDR_EVENT, 32'h3ff, tfsl_pkg::TFSL_RESP_OKAY);
    axr(tfsl_pkg::TFSL_ADDR_EVENT, 32'h0, tfsl_pkg::TFSL_RESP_OKAY);
    axw(tfsl_pkg::TFSL_ADDR_MASK, 32'h40, tfsl_pkg::TFSL_RESP_OKAY);
    @(posedge clock);
    fuse_blown <= 1'b1;
    settle();
    chk("irq", irq, 1'b1);
    axr(tfsl_pkg::TFSL_ADDR_STATUS, 32'h40, tfsl_pkg::TFSL_RESP_OKAY);
    axr(tfsl_pkg::TFSL_ADDR_EVENT, 32'h40, tfsl_pkg::TFSL_RESP_OKAY);
    axw(tfsl_pkg::TFSL_ADDR_MASK, 32'h0, tfsl_pkg::TFSL_RESP_OKAY);
    chk("irq_masked", irq, 1'b0);
    axw(tfsl_pkg::TFSL_ADDR_MASK, 32'h40, tfsl_pkg::TFSL_RESP_OKAY);
    @(posedge clock);
    fuse_blown <= 1'b0;
    settle();
    axw(tfsl_pkg::TFSL_ADDR_EVENT, 32'h40, tfsl_pkg::TFSL_RESP_OKAY);
    chk("irq_cleared", irq, 1'b0);
    axr(8'h10, 32'h0, tfsl_pkg::TFSL_RESP_SLVERR);
    axw(8'h10, 32'h1, tfsl_pkg::TFSL_RESP_SLVERR);
    @(posedge clock);
    pa_supply_on <= 1'b0;
    settle();
    chk("osc_idle", osc_enable, 1'b0);
    axw(tfsl_pkg::TFSL_ADDR_CTRL, 32'h1, tfsl_pkg::TFSL_RESP_OKAY);
    settle();
    chk("osc_soft_test", osc_enable, 1'b1);
  endtask : t_regs
  // ------------------------------------------------------------
  // Clock, reset, run
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {rst_b, conv_error, fuse_blown, osc_loss, buf_loss, pre_loss, amp_held} = 7'h00;
    {turn_on_request, osc_test_button, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    s_axi_wstrb = 4'hf;
    reg_fault = 5'h00;
    tx_on = 1'b1;
    pa_supply_on = 1'b1;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_supply();
    t_conv();
    t_rf();
    t_osc();
    t_regs();
    test_done();
  end
endmodule : tfsl_top_tb
`default_nettype wire
